//--- verilog/ast_uart.sv
// Asynchronous serial transceiver with AHB-Lite register access
`timescale 1ns/1ns
`include "ast_map.svh"

// Summary of operation
// - Frame is low start bit, data, optional parity, then high stop bits.
// - Transmitter sends one or two stop bits per stop-length bit.
// - Parity enable and odd/even type shared by transmit and receive.
// - Code 000 gives 76800 baud at 16 MHz; each code halves, down to 2400 at code 101.
// - Code 110 takes the transfer clock from timer five; baud is it over 16.
// - Timer transfer clock is source clock divided by the period register.
// - Idle receiver samples line with selected clock until it sees low.
// - Each bit sampled at sub-ticks 7, 8, 9; majority of three wins.
// - Buffer write after status read clears empty flag and sends the byte.
// - Start of shifting sets the empty flag and pulses the transmit irq.
// - Transmit line high until the first byte is written, and while disabled once the frame in progress ends.
// - After stop bit, data goes to receive buffer, full flag and irq raised.
// - New character on full buffer sets overrun and is discarded.
// - No further reception while the overrun flag is set.
// - Receive disable takes effect after the character in progress ends.
// - Parity mismatch on received data sets the parity error flag.
// - A zero sampled in the stop bit sets the framing error flag.
// - Status read then buffer read clears error and full flags.
// - Overrun set between status read and buffer read survives the buffer read.
// - Transmit end set when frame done and buffer empty; cleared at next start.
// - Fixed codes divide the clock by 13, 26, doubling per code.
module ast_uart (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        rxd,
    output logic             txd,
    output logic             transmit_irq,
    output logic             receive_irq
);

    // Sub-tick divisor: fixed codes or timer five period
    function automatic logic [8:0] baud_div(input logic [2:0] code, input logic [7:0] period);
        if (code <= `AST_DIV_MAX_CODE)
            baud_div = `AST_BASE_DIV << code;
        else if (code == `AST_BAUD_TIMER)
            baud_div = (period == 8'h00) ? `AST_PERIOD_FULL : {1'b0, period};
        else
            baud_div = 9'h000;
    endfunction

    // Majority of three samples
    function automatic logic vote(input logic [2:0] s);
        vote = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction

    ast_pkg::ast_ctrl_t     serial_control_reg;
    logic [7:0]             timer_five_period;
    logic [7:0]             transmit_buffer;
    logic [7:0]             receive_buffer;
    logic                   tx_buffer_empty_flag;
    logic                   transmit_end_flag;
    logic                   rx_buffer_full_flag;
    logic                   parity_error_flag;
    logic                   framing_error_flag;
    logic                   overrun_flag;
    logic                   tx_armed;
    logic                   rx_armed;
    logic                   ovr_seen;
    ast_pkg::ast_req_t      req;
    logic                   pend;
    logic [8:0]             div_cnt;
    logic                   subtick;
    logic                   rxd_meta;
    logic                   rxd_sync;
    ast_pkg::ast_tx_state_t tx_state;
    logic [3:0]             tx_rt;
    logic [2:0]             tx_bit;
    logic [7:0]             tx_shift;
    logic                   tx_stop2;
    ast_pkg::ast_rx_state_t rx_state;
    logic [3:0]             rx_rt;
    logic [2:0]             rx_bit;
    logic [7:0]             rx_shift;
    logic [2:0]             rx_samp;
    logic                   rx_par;

    // Decoded data-phase actions, shifter strobes and the selected divisor
    logic       wr_ctrl;
    logic       wr_period;
    logic       wr_data;
    logic       rd_status;
    logic       rd_data;
    logic       tx_go;
    logic       tx_bit_end;
    logic       rx_bit_end;
    logic       rx_val;
    logic       rx_done;
    logic       rx_ovr;
    logic [8:0] div_now;

    assign wr_ctrl   = pend & req.write & (req.index == `AST_IDX_CTRL);
    assign wr_period = pend & req.write & (req.index == `AST_IDX_PERIOD);
    assign wr_data   = pend & req.write & (req.index == `AST_IDX_DATA);
    assign rd_status = pend & ~req.write & (req.index == `AST_IDX_STATUS);
    assign rd_data   = pend & ~req.write & (req.index == `AST_IDX_DATA);
    assign div_now   = baud_div(serial_control_reg.baud_select, timer_five_period);
    // Byte starts only on a sub-tick, from idle, with the buffer full
    assign tx_go      = subtick & (tx_state == ast_pkg::TX_IDLE) & ~tx_buffer_empty_flag
                      & serial_control_reg.transmit_enable;
    assign tx_bit_end = subtick & (tx_rt == `AST_RT_LAST);
    assign rx_bit_end = subtick & (rx_rt == `AST_RT_LAST);
    assign rx_val     = vote(rx_samp);
    assign rx_done    = rx_bit_end & (rx_state == ast_pkg::RX_STOP);
    assign rx_ovr     = rx_done & rx_buffer_full_flag;

    // Bus slave: one wait state so that read data leave a flip-flop
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pend      <= 1'b0;
            req       <= '0;
            hreadyout <= 1'b1;
            hrdata    <= 32'h0000_0000;
        end
        else if (pend)
        begin
            pend      <= 1'b0;
            hreadyout <= 1'b1;
            if (rd_status)
                hrdata <= {24'h00_0000, parity_error_flag, framing_error_flag, overrun_flag,
                           rx_buffer_full_flag, transmit_end_flag, tx_buffer_empty_flag, 2'b00};
            else if (rd_data)
                hrdata <= {24'h00_0000, receive_buffer};
            else if (!req.write && req.index == `AST_IDX_PERIOD)
                hrdata <= {24'h00_0000, timer_five_period};
            else
                hrdata <= 32'h0000_0000;
        end
        else if (hsel && hready && htrans[1] == `AST_HTRANS_NSEQ)
        begin
            pend      <= 1'b1;
            req       <= '{index: haddr[15:2], write: hwrite};
            hreadyout <= 1'b0;
        end
    end

    assign hresp = `AST_HRESP_OKAY;

    // Software-written configuration; baud code changes on any control write
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            serial_control_reg <= `AST_CTRL_RST;
            timer_five_period  <= `AST_PERIOD_RST;
        end
        else
        begin
            if (wr_ctrl)
                serial_control_reg <= hwdata[7:0];
            if (wr_period)
                timer_five_period <= hwdata[7:0];
        end
    end

    // Sub-tick divider: sixteen sub-ticks per bit
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            div_cnt <= 9'h000;
            subtick <= 1'b0;
        end
        else if (div_now == 9'h000)
        begin
            div_cnt <= 9'h000;
            subtick <= 1'b0;
        end
        else if (div_cnt + `AST_DIV_ONE >= div_now)
        begin
            div_cnt <= 9'h000;
            subtick <= 1'b1;
        end
        else
        begin
            div_cnt <= div_cnt + `AST_DIV_ONE;
            subtick <= 1'b0;
        end
    end

    // Arming by a status read; a later buffer access consumes it
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tx_armed <= 1'b0;
            rx_armed <= 1'b0;
            ovr_seen <= 1'b0;
        end
        else if (rd_status)
        begin
            tx_armed <= 1'b1;
            rx_armed <= 1'b1;
            ovr_seen <= overrun_flag;
        end
        else
        begin
            if (wr_data)
                tx_armed <= 1'b0;
            if (rd_data)
                rx_armed <= 1'b0;
        end
    end

    // Transmit buffer and its empty flag; a fresh write keeps the buffer full
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            transmit_buffer      <= `AST_DATA_RST;
            tx_buffer_empty_flag <= 1'b1;
        end
        else if (wr_data && tx_armed)
        begin
            transmit_buffer      <= hwdata[7:0];
            tx_buffer_empty_flag <= 1'b0;
        end
        else if (tx_go)
            tx_buffer_empty_flag <= 1'b1;
    end

    // Transmit shifter
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tx_state          <= ast_pkg::TX_IDLE;
            tx_rt             <= 4'h0;
            tx_bit            <= 3'h0;
            tx_shift          <= 8'h00;
            tx_stop2          <= 1'b0;
            txd               <= 1'b1;
            transmit_irq      <= 1'b0;
            transmit_end_flag <= 1'b1;
        end
        else
        begin
            transmit_irq <= tx_go;
            if (subtick && tx_state != ast_pkg::TX_IDLE)
                tx_rt <= tx_rt + 4'h1;
            unique case (tx_state)
                ast_pkg::TX_IDLE:
                    if (tx_go)
                    begin
                        tx_state          <= ast_pkg::TX_START;
                        tx_rt             <= 4'h0;
                        tx_shift          <= transmit_buffer;
                        tx_stop2          <= 1'b0;
                        txd               <= 1'b0;
                        transmit_end_flag <= 1'b0;
                    end
                ast_pkg::TX_START:
                    if (tx_bit_end)
                    begin
                        tx_state <= ast_pkg::TX_DATA;
                        tx_bit   <= 3'h0;
                        txd      <= tx_shift[0];
                    end
                ast_pkg::TX_DATA:
                    if (tx_bit_end)
                    begin
                        if (tx_bit == `AST_BIT_LAST)
                        begin
                            tx_state <= serial_control_reg.parity_enable
                                      ? ast_pkg::TX_PAR : ast_pkg::TX_STOP;
                            txd      <= serial_control_reg.parity_enable
                                      ? (^tx_shift) ^ ~serial_control_reg.parity_even
                                      : 1'b1;
                        end
                        else
                            txd <= tx_shift[tx_bit + 3'h1];
                        tx_bit <= tx_bit + 3'h1;
                    end
                ast_pkg::TX_PAR:
                    if (tx_bit_end)
                    begin
                        tx_state <= ast_pkg::TX_STOP;
                        txd      <= 1'b1;
                    end
                ast_pkg::TX_STOP:
                    if (tx_bit_end)
                    begin
                        if (serial_control_reg.stop_length_sel && !tx_stop2)
                            tx_stop2 <= 1'b1;
                        else
                        begin
                            tx_state          <= ast_pkg::TX_IDLE;
                            transmit_end_flag <= tx_buffer_empty_flag;
                        end
                    end
            endcase
        end
    end

    // Receive line synchroniser
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rxd_meta <= 1'b1;
            rxd_sync <= 1'b1;
        end
        else
        begin
            rxd_meta <= rxd;
            rxd_sync <= rxd_meta;
        end
    end

    // Receive framer; enable is looked at only when a frame could begin
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rx_state <= ast_pkg::RX_IDLE;
            rx_rt    <= 4'h0;
            rx_bit   <= 3'h0;
            rx_shift <= 8'h00;
            rx_samp  <= 3'h0;
            rx_par   <= 1'b0;
        end
        else if (subtick)
        begin
            if (rx_state != ast_pkg::RX_IDLE)
                rx_rt <= rx_rt + 4'h1;
            if (rx_rt == `AST_RT_S0 || rx_rt == `AST_RT_S1 || rx_rt == `AST_RT_S2)
                rx_samp <= {rx_samp[1:0], rxd_sync};
            unique case (rx_state)
                ast_pkg::RX_IDLE:
                    if (!rxd_sync && serial_control_reg.receive_enable && !overrun_flag)
                    begin
                        rx_state <= ast_pkg::RX_START;
                        rx_rt    <= 4'h0;
                    end
                ast_pkg::RX_START:
                    if (rx_rt == `AST_RT_LAST)
                    begin
                        rx_state <= rx_val ? ast_pkg::RX_IDLE : ast_pkg::RX_DATA;
                        rx_bit   <= 3'h0;
                    end
                ast_pkg::RX_DATA:
                    if (rx_rt == `AST_RT_LAST)
                    begin
                        rx_shift <= {rx_val, rx_shift[7:1]};
                        rx_bit   <= rx_bit + 3'h1;
                        if (rx_bit == `AST_BIT_LAST)
                            rx_state <= serial_control_reg.parity_enable
                                      ? ast_pkg::RX_PAR : ast_pkg::RX_STOP;
                    end
                ast_pkg::RX_PAR:
                    if (rx_rt == `AST_RT_LAST)
                    begin
                        rx_par   <= rx_val;
                        rx_state <= ast_pkg::RX_STOP;
                    end
                ast_pkg::RX_STOP:
                    if (rx_rt == `AST_RT_LAST)
                        rx_state <= ast_pkg::RX_IDLE;
            endcase
        end
    end

    // Receive buffer and flags; new events win over the clearing read
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            receive_buffer      <= `AST_DATA_RST;
            rx_buffer_full_flag <= 1'b0;
            parity_error_flag   <= 1'b0;
            framing_error_flag  <= 1'b0;
            overrun_flag        <= 1'b0;
            receive_irq         <= 1'b0;
        end
        else
        begin
            receive_irq <= rx_done & ~rx_buffer_full_flag;
            if (rd_data && rx_armed)
            begin
                rx_buffer_full_flag <= 1'b0;
                parity_error_flag   <= 1'b0;
                framing_error_flag  <= 1'b0;
                if (ovr_seen)
                    overrun_flag <= 1'b0;
            end
            if (rx_ovr)
                overrun_flag <= 1'b1;
            else if (rx_done)
            begin
                receive_buffer      <= rx_shift;
                rx_buffer_full_flag <= 1'b1;
                parity_error_flag   <= serial_control_reg.parity_enable
                    & ((^rx_shift) ^ ~serial_control_reg.parity_even ^ rx_par);
                framing_error_flag  <= ~rx_val;
            end
        end
    end

    // Checks
    chk_txd_idle_high: assert property (@(posedge hclk) disable iff (!hresetn)
        tx_state == ast_pkg::TX_IDLE |-> txd)
        else $error("transmit line low while idle");
    chk_start_bit_low: assert property (@(posedge hclk) disable iff (!hresetn)
        tx_state == ast_pkg::TX_START |-> !txd)
        else $error("start bit not low");
    chk_tx_go_flags: assert property (@(posedge hclk) disable iff (!hresetn)
        tx_go && !(wr_data && tx_armed) |=> tx_buffer_empty_flag && transmit_irq
        && !transmit_end_flag)
        else $error("start of shifting did not set empty flag and irq");
    chk_write_fills: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_data && tx_armed |=> !tx_buffer_empty_flag ##0 transmit_buffer == $past(hwdata[7:0]))
        else $error("armed write did not fill the buffer");
    chk_unarmed_write: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_data && !tx_armed && tx_buffer_empty_flag && !tx_go |=> tx_buffer_empty_flag)
        else $error("unarmed write cleared the empty flag");
    chk_ovr_discard: assert property (@(posedge hclk) disable iff (!hresetn)
        rx_ovr |=> overrun_flag && $stable(receive_buffer))
        else $error("overrun did not keep the buffer");
    chk_ovr_blocks: assert property (@(posedge hclk) disable iff (!hresetn)
        rx_state == ast_pkg::RX_IDLE && overrun_flag |=> rx_state == ast_pkg::RX_IDLE)
        else $error("reception started during overrun");
    chk_rx_load: assert property (@(posedge hclk) disable iff (!hresetn)
        rx_done && !rx_buffer_full_flag |=> rx_buffer_full_flag && receive_irq
        ##1 !receive_irq)
        else $error("received byte not loaded");
    chk_flag_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_data && rx_armed && !rx_done |=> !rx_buffer_full_flag && !framing_error_flag)
        else $error("buffer read after status read left flags set");

endmodule

//--- verilog/ast_map.svh
// Register indices, reset values, baud divisors and timing counts of the serial transceiver
`ifndef AST_MAP_SVH
`define AST_MAP_SVH

// Register indices; the byte address is four times the index
`define AST_IDX_CTRL     14'h0025
`define AST_IDX_STATUS   14'h0025
`define AST_IDX_DATA     14'h0F9B
`define AST_IDX_PERIOD   14'h0026

// Reset values
`define AST_CTRL_RST     8'h00
`define AST_PERIOD_RST   8'h0D
`define AST_DATA_RST     8'h00

// Baud generation
`define AST_BASE_DIV     9'h00D
`define AST_DIV_ONE      9'h001
`define AST_DIV_MAX_CODE 3'h5
`define AST_BAUD_TIMER   3'h6
`define AST_PERIOD_FULL  9'h100

// Receiver sample sub-ticks, last sub-tick of a bit and last data bit index
`define AST_RT_S0        4'h7
`define AST_RT_S1        4'h8
`define AST_RT_S2        4'h9
`define AST_RT_LAST      4'hF
`define AST_BIT_LAST     3'h7

// AHB-Lite codes
`define AST_HTRANS_NSEQ  1'b1
`define AST_HRESP_OKAY   1'b0

`endif

//--- verilog/ast_pkg.sv
// Types shared by the serial transceiver
package ast_pkg;

    // Control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic       transmit_enable;
        logic       receive_enable;
        logic       stop_length_sel;
        logic       parity_even;
        logic       parity_enable;
        logic [2:0] baud_select;
    } ast_ctrl_t;

    // Captured AHB address phase
    typedef struct packed {
        logic [13:0] index;
        logic        write;
    } ast_req_t;

    typedef enum logic [4:0] {
        TX_IDLE  = 5'b0_0001,
        TX_START = 5'b0_0010,
        TX_DATA  = 5'b0_0100,
        TX_PAR   = 5'b0_1000,
        TX_STOP  = 5'b1_0000
    } ast_tx_state_t;

    typedef enum logic [4:0] {
        RX_IDLE  = 5'b0_0001,
        RX_START = 5'b0_0010,
        RX_DATA  = 5'b0_0100,
        RX_PAR   = 5'b0_1000,
        RX_STOP  = 5'b1_0000
    } ast_rx_state_t;

endpackage

//--- tb/ast_remote.sv
// Remote serial device model facing the transceiver's serial pins
`timescale 1ns/1ns
module ast_remote (
    input  wire logic hclk,
    input  wire logic txd,
    output logic      rxd
);
    // Line idles high, as a pulled-up serial line would
    initial rxd = 1'b1;

    // Send one frame, 16 clocks per bit, parity always present
    task automatic send(input logic [7:0] d, input logic pbit, input logic stop);
        logic [10:0] f;
        f = {stop, pbit, d, 1'b0};
        for (int i = 0; i < 11; i++)
        begin
            rxd <= f[i];
            repeat (16) @(posedge hclk);
        end
        rxd <= 1'b1;
        repeat (32) @(posedge hclk);
    endtask

    // Capture a frame at mid-bit; g counts high clocks after the mid-bit sample of the first stop
    task automatic recv(input logic pen, output logic [7:0] d, output logic p,
                        output logic s, output int g);
        // Level, not edge: a back-to-back start is already low when called
        wait (txd === 1'b0);
        repeat (8) @(posedge hclk);
        for (int i = 0; i < 8; i++)
        begin
            repeat (16) @(posedge hclk);
            d[i] = txd;
        end
        p = 1'b1;
        if (pen)
        begin
            repeat (16) @(posedge hclk);
            p = txd;
        end
        repeat (16) @(posedge hclk);
        s = txd;
        g = 0;
        while (txd === 1'b1 && g < 100)
        begin
            @(posedge hclk);
            g++;
        end
    endtask
endmodule

//--- tb/tb_async_serial_transceiver.sv
// Testbench for the serial transceiver: bus tasks, remote device, flag checks
`timescale 1ns/1ns
`include "ast_map.svh"
module tb_async_serial_transceiver;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic        hready, hreadyout, hresp, txd, rxd, tx_irq, rx_irq, p, s;
    logic [31:0] hrdata, rd;
    logic [7:0]  d;
    logic [7:0]  cfg [3] = '{8'hC6, 8'hEE, 8'hFE};
    int          g, g2, bad_count = 0, check_count = 0;
    int          tx_n = 0, rx_n = 0;

    // 4 ns period; the slave's ready closes the bus loop
    always #2 hclk = ~hclk;
    assign hready = hreadyout;

    // Irq pulses are counted; each sent frame and each byte loaded into the receive buffer gives exactly one
    always @(posedge hclk)
    begin
        if (tx_irq === 1'b1)
            tx_n++;
        if (rx_irq === 1'b1)
            rx_n++;
    end

    ast_uart ast_uart_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rxd(rxd), .txd(txd),
        .transmit_irq(tx_irq), .receive_irq(rx_irq));
    ast_remote ast_remote_inst (.hclk(hclk), .txd(txd), .rxd(rxd));

    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] got);
        check_count++;
        if (got !== e)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, e, got);
        end
    endtask

    // One single transfer; both phases wait on ready, never on a fixed count
    task automatic bus(input logic w, input logic [13:0] idx, input logic [31:0] wd);
        haddr  <= {16'h0000, idx, 2'h0};
        hwrite <= w;
        htrans <= 2'h2;
        hsel   <= 1'b1;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task automatic st(input logic [31:0] e);
        bus(1'b0, `AST_IDX_STATUS, 32'h0000_0000);
        chk("status", e, rd);
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Run takes about 3000 clocks; a hang is cut at over six times that
    initial
    begin
        repeat (20000) @(posedge hclk);
        bad_count++;
        conclude();
    end

    initial
    begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, 14'h0100, 32'h0000_0000);
        chk("unmapped", 32'h0000_0000, rd);
        chk("hresp", 32'h0000_0000, {31'h0, hresp});
        bus(1'b1, `AST_IDX_PERIOD, 32'h0000_0001);
        bus(1'b1, `AST_IDX_CTRL, 32'h0000_00FE);
        // A write with no status read in front must not send anything
        bus(1'b1, `AST_IDX_DATA, 32'h0000_0055);
        repeat (40) @(posedge hclk);
        chk("txd idle", 32'h0000_0001, {31'h0, txd});
        st(32'h0000_000C);
        for (int i = 0; i < 3; i++)
        begin
            bus(1'b1, `AST_IDX_CTRL, {24'h0, cfg[i]});
            st(32'h0000_000C);
            // Second byte queued during the first frame tests stop length
            fork
                begin
                    bus(1'b1, `AST_IDX_DATA, 32'h0000_0031);
                    wait (txd === 1'b0);
                    @(posedge hclk);
                    st(32'h0000_0004);
                    bus(1'b1, `AST_IDX_DATA, 32'h0000_0031);
                end
                begin
                    ast_remote_inst.recv(cfg[i][3], d, p, s, g);
                    ast_remote_inst.recv(cfg[i][3], d, p, s, g2);
                end
            join
            chk("tx data", 32'h0000_0031, {24'h0, d});
            chk("tx parity", {31'h0, cfg[i][3] ? (cfg[i][4] ? 1'b1 : 1'b0) : 1'b1},
                {31'h0, p});
            chk("tx stop", 32'h0000_0001, {31'h0, s});
            chk("stop count", cfg[i][5] ? 32'h2 : 32'h1, (g + 7) / 16);
            rd = 32'h0000_0000;
            for (int n = 0; n < 20 && rd[3] !== 1'b1; n++)
                bus(1'b0, `AST_IDX_STATUS, 32'h0000_0000);
            chk("tx end", 32'h0000_000C, rd);
        end
        // Receive: clean frame, then bad parity with bad stop, then overrun
        ast_remote_inst.send(8'h3C, 1'b0, 1'b1);
        st(32'h0000_001C);
        bus(1'b0, `AST_IDX_DATA, 32'h0000_0000);
        chk("rx data", 32'h0000_003C, rd);
        st(32'h0000_000C);
        ast_remote_inst.send(8'h3C, 1'b1, 1'b0);
        st(32'h0000_00DC);
        bus(1'b0, `AST_IDX_DATA, 32'h0000_0000);
        st(32'h0000_000C);
        ast_remote_inst.send(8'h11, 1'b0, 1'b1);
        ast_remote_inst.send(8'h22, 1'b0, 1'b1);
        st(32'h0000_003C);
        ast_remote_inst.send(8'h44, 1'b0, 1'b1);
        bus(1'b0, `AST_IDX_DATA, 32'h0000_0000);
        chk("rx kept", 32'h0000_0011, rd);
        st(32'h0000_000C);
        // Overrun arriving after the status read must survive the buffer read
        ast_remote_inst.send(8'h55, 1'b0, 1'b1);
        st(32'h0000_001C);
        ast_remote_inst.send(8'h66, 1'b0, 1'b1);
        bus(1'b0, `AST_IDX_DATA, 32'h0000_0000);
        st(32'h0000_002C);
        bus(1'b0, `AST_IDX_DATA, 32'h0000_0000);
        chk("rx kept", 32'h0000_0055, rd);
        st(32'h0000_000C);
        chk("tx irq count", 32'd6, tx_n);
        chk("rx irq count", 32'd4, rx_n);
        conclude();
    end
endmodule
